// [core/dram_cmd_if.sv]
// Command link between the memory controller and the DRAM mode logic.
`timescale 1ns/1ps
`default_nettype none
interface dram_cmd_if;
	logic ck;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [2:0] ba;
	logic [12:0] addr;
	logic [7:0] dq_from_dev;
	logic dq_oe;
	logic dq_valid;
	logic odt;
	logic [1:0] term_sel;
	logic level_en;
	modport device (input ck, cs_n, ras_n, cas_n, we_n, ba, addr, odt,
		output dq_from_dev, dq_oe, dq_valid, term_sel, level_en);
	modport controller (output ck, cs_n, ras_n, cas_n, we_n, ba, addr, odt,
		input dq_from_dev, dq_oe, dq_valid, term_sel, level_en);
endinterface
`default_nettype wire

// [core/dram_mode_controller.sv]
// Controller end: APB registers, command issue and refresh pacing.
`timescale 1ns/1ps
`default_nettype none
`include "mode_reg_defines.svh"
module dram_mode_controller #(
	parameter int REFI_NORMAL_CYC = `REFI_NORMAL_NS / `CLK_NS,
	parameter int REFI_HOT_CYC = `REFI_HOT_NS / `CLK_NS
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	dram_cmd_if.controller link,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SETUP = 2'b01,
		ST_HOLD = 2'b10
	} ctl_state_t;
	ctl_state_t st_r, st_nxt;
	logic [3:0] div_r, div_nxt;
	logic ck_r, ck_nxt;
	logic [2:0] cmd_r, cmd_nxt, pend_cmd_r, pend_cmd_nxt;
	logic [2:0] ba_r, ba_nxt, pend_ba_r, pend_ba_nxt;
	logic [12:0] ad_r, ad_nxt, pend_ad_r, pend_ad_nxt;
	logic busy_r, busy_nxt, hot_r, hot_nxt;
	logic [12:0] mr2_r, mr2_nxt, mr3_r, mr3_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic rdy_r, rdy_nxt, err_r, err_nxt;
	logic [7:0] last_dq_r, last_dq_nxt;
	logic [31:0] refi_r, refi_nxt;
	logic ref_due_r, ref_due_nxt;
	logic wr_acc, rd_acc, ck_fall;
	logic [12:0] clean;
	logic [2:0] go_cmd;
	logic allowed;

	// APB strobes; the slave answers one cycle into the access phase.
	always_comb begin
		wr_acc = psel_in && penable_in && pwrite_in && !rdy_r;
		rd_acc = psel_in && penable_in && !pwrite_in && !rdy_r;
		ck_fall = (div_r == `LINK_DIV) && ck_r;
		go_cmd = pwdata_in[2:0];
		if (pwdata_in[5:3] == `BANK_MR2) begin
			clean = pwdata_in[18:6] & ~`MR2_RSVD_MASK;
		end else if (pwdata_in[5:3] == `BANK_MR3) begin
			clean = pwdata_in[18:6] & ~`MR3_RSVD_MASK;
		end else begin
			clean = pwdata_in[18:6];
		end
		// While the pattern is on, only reads or any mode-register write to register three pass.
		allowed = !mr3_r[`MR3_PAT_EN_BIT] || go_cmd == 3'(mode_reg_pkg::CMD_READ)
			|| go_cmd == 3'(mode_reg_pkg::CMD_READ_AP)
			|| (go_cmd == 3'(mode_reg_pkg::CMD_MRS) && pwdata_in[5:3] == `BANK_MR3);
		if (go_cmd == 3'(mode_reg_pkg::CMD_SELF_REF) && hot_r && !mr2_r[`MR2_SRT_BIT]) begin
			allowed = 1'b0;
		end
	end

	// Register file, pending command and refresh timer.
	always_comb begin
		st_nxt = st_r;
		rdy_nxt = psel_in && penable_in && !rdy_r;
		err_nxt = 1'b0;
		rd_nxt = 32'h0;
		pend_cmd_nxt = pend_cmd_r;
		pend_ba_nxt = pend_ba_r;
		pend_ad_nxt = pend_ad_r;
		busy_nxt = busy_r;
		hot_nxt = hot_r;
		mr2_nxt = mr2_r;
		mr3_nxt = mr3_r;
		last_dq_nxt = link.dq_valid ? link.dq_from_dev : last_dq_r;
		refi_nxt = refi_r + 32'h1;
		ref_due_nxt = ref_due_r;
		if (refi_r >= 32'(hot_r ? REFI_HOT_CYC : REFI_NORMAL_CYC)) begin
			refi_nxt = 32'h0;
			ref_due_nxt = 1'b1;
		end
		if (wr_acc) begin
			if (paddr_in == `APB_CTRL) begin
				hot_nxt = pwdata_in[0];
			end else if (paddr_in == `APB_MR_DATA) begin
				if (busy_r || !allowed) begin
					err_nxt = 1'b1;
				end else begin
					pend_cmd_nxt = go_cmd;
					pend_ba_nxt = pwdata_in[5:3];
					pend_ad_nxt = clean;
					busy_nxt = 1'b1;
					if (go_cmd == 3'(mode_reg_pkg::CMD_MRS) && pwdata_in[5:3] == `BANK_MR2) begin
						mr2_nxt = clean;
					end
					if (go_cmd == 3'(mode_reg_pkg::CMD_MRS) && pwdata_in[5:3] == `BANK_MR3) begin
						mr3_nxt = clean;
					end
				end
			end else begin
				err_nxt = 1'b1;
			end
		end else if (rd_acc) begin
			if (paddr_in == `APB_CTRL) begin
				rd_nxt = {31'h0, hot_r};
			end else if (paddr_in == `APB_STATUS) begin
				rd_nxt = {22'h0, last_dq_r, ref_due_r, busy_r};
			end else if (paddr_in == `APB_MR2) begin
				rd_nxt = {19'h0, mr2_r};
			end else if (paddr_in == `APB_MR3) begin
				rd_nxt = {19'h0, mr3_r};
			end else begin
				err_nxt = 1'b1;
			end
		end
		// Pending commands (and refresh) launch on the link clock's falling edge.
		case (st_r)
			ST_IDLE: begin
				if (ck_fall && busy_r) begin
					st_nxt = ST_SETUP;
				end else if (ck_fall && ref_due_r && !mr3_r[`MR3_PAT_EN_BIT]) begin
					st_nxt = ST_HOLD;
				end
			end
			ST_SETUP: begin
				if (ck_fall) begin
					st_nxt = ST_IDLE;
					busy_nxt = 1'b0;
				end
			end
			ST_HOLD: begin
				// A timer tick in the same cycle keeps the refresh request pending.
				if (ck_fall) begin
					st_nxt = ST_IDLE;
					if (refi_nxt != 32'h0) begin
						ref_due_nxt = 1'b0;
					end
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	// Link clock divider and the command pins it paces.
	always_comb begin
		div_nxt = (div_r == `LINK_DIV) ? 4'h0 : 4'(div_r + 4'h1);
		ck_nxt = (div_r == `LINK_DIV) ? !ck_r : ck_r;
		cmd_nxt = cmd_r;
		ba_nxt = ba_r;
		ad_nxt = ad_r;
		if (ck_fall) begin
			cmd_nxt = 3'(mode_reg_pkg::CMD_NOP);
			if (st_r == ST_IDLE && busy_r) begin
				cmd_nxt = pend_cmd_r;
				ba_nxt = pend_ba_r;
				ad_nxt = pend_ad_r;
			end else if (st_r == ST_IDLE && ref_due_r && !mr3_r[`MR3_PAT_EN_BIT]) begin
				cmd_nxt = 3'(mode_reg_pkg::CMD_REFRESH);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_r <= ST_IDLE;
			div_r <= 4'h0;
			ck_r <= 1'b0;
			cmd_r <= 3'h0;
			ba_r <= 3'h0;
			ad_r <= 13'h0000;
			pend_cmd_r <= 3'h0;
			pend_ba_r <= 3'h0;
			pend_ad_r <= 13'h0000;
			busy_r <= 1'b0;
			hot_r <= 1'b0;
			mr2_r <= 13'h0000;
			mr3_r <= 13'h0000;
			rd_r <= 32'h0;
			rdy_r <= 1'b0;
			err_r <= 1'b0;
			last_dq_r <= 8'h00;
			refi_r <= 32'h0;
			ref_due_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			div_r <= div_nxt;
			ck_r <= ck_nxt;
			cmd_r <= cmd_nxt;
			ba_r <= ba_nxt;
			ad_r <= ad_nxt;
			pend_cmd_r <= pend_cmd_nxt;
			pend_ba_r <= pend_ba_nxt;
			pend_ad_r <= pend_ad_nxt;
			busy_r <= busy_nxt;
			hot_r <= hot_nxt;
			mr2_r <= mr2_nxt;
			mr3_r <= mr3_nxt;
			rd_r <= rd_nxt;
			rdy_r <= rdy_nxt;
			err_r <= err_nxt;
			last_dq_r <= last_dq_nxt;
			refi_r <= refi_nxt;
			ref_due_r <= ref_due_nxt;
		end
	end

	// Command encoding onto the pins: MRS all low, read CAS low, write CAS and WE low.
	assign link.ck = ck_r;
	assign link.cs_n = (cmd_r == 3'(mode_reg_pkg::CMD_NOP));
	assign link.ras_n = !(cmd_r == 3'(mode_reg_pkg::CMD_MRS) || cmd_r[2:1] == 2'b11
		|| cmd_r == 3'(mode_reg_pkg::CMD_REFRESH));
	assign link.cas_n = (cmd_r == 3'(mode_reg_pkg::CMD_NOP));
	assign link.we_n = !(cmd_r == 3'(mode_reg_pkg::CMD_MRS) || cmd_r == 3'(mode_reg_pkg::CMD_WRITE));
	assign link.ba = ba_r;
	assign link.addr = ad_r;
	assign link.odt = (cmd_r == 3'(mode_reg_pkg::CMD_WRITE));
	assign prdata_out = rd_r;
	assign pready_out = rdy_r;
	assign pslverr_out = err_r;
endmodule
`default_nettype wire

// [core/dram_mode_reg_two_three_decode.sv]
// DRAM-side mode-register decode: registers one to three and their effects.
`timescale 1ns/1ps
`default_nettype none
`include "mode_reg_defines.svh"
module dram_mode_reg_two_three_decode (
	input wire logic clk_in,
	input wire logic rst_n_in,
	dram_cmd_if.device link,
	output logic [2:0] partial_array_retention_out,
	output logic hot_self_refresh_rate_out,
	output logic [3:0] total_write_delay_out,
	output logic write_fire_out
);
	// Link pins pass three flops; a link clock change counts when stages two and three agree.
	logic [2:0] ck_s_r, ck_s_nxt;
	logic ck_q_r, ck_q_nxt;
	logic [2:0] cs_s_r, ras_s_r, cas_s_r, we_s_r;
	logic [2:0] cs_s_nxt, ras_s_nxt, cas_s_nxt, we_s_nxt;
	logic [8:0] ba_s_r, ba_s_nxt;
	logic [38:0] ad_s_r, ad_s_nxt;
	logic [2:0] odt_s_r, odt_s_nxt;
	logic [12:0] mr1_r, mr1_nxt, mr2_r, mr2_nxt, mr3_r, mr3_nxt;
	logic [7:0] rdq_r, rdq_nxt;
	logic rvalid_r, rvalid_nxt, roe_r, roe_nxt;
	logic [1:0] term_r, term_nxt;
	logic [15:0] al_pipe_r, al_pipe_nxt;
	logic [15:0] wr_pipe_r, wr_pipe_nxt;
	logic fire_r, fire_nxt;
	logic [2:0] partial_array_retention_r, partial_array_retention_nxt;
	logic srt_r, srt_nxt;
	logic [3:0] wl_r, wl_nxt;
	logic lvl_r, lvl_nxt;
	logic ck_rise;
	logic cs_n, ras_n, cas_n, we_n;
	logic [2:0] ba;
	logic [12:0] addr;
	logic [3:0] al_cyc, cwl_cyc;
	logic is_mrs, is_rd, is_wr;

	// Sample stages; the rest reads stage three, and the clock the filtered ck_q_r.
	always_comb begin
		ck_s_nxt = {ck_s_r[1:0], link.ck};
		cs_s_nxt = {cs_s_r[1:0], link.cs_n};
		ras_s_nxt = {ras_s_r[1:0], link.ras_n};
		cas_s_nxt = {cas_s_r[1:0], link.cas_n};
		we_s_nxt = {we_s_r[1:0], link.we_n};
		ba_s_nxt = {ba_s_r[5:0], link.ba};
		ad_s_nxt = {ad_s_r[25:0], link.addr};
		odt_s_nxt = {odt_s_r[1:0], link.odt};
		ck_q_nxt = (ck_s_r[1] == ck_s_r[2]) ? ck_s_r[2] : ck_q_r;
	end

	// Command fields are taken from the third stage at a filtered clock rise.
	always_comb begin
		ck_rise = (ck_s_r[1] == ck_s_r[2]) && ck_s_r[2] && !ck_q_r;
		cs_n = cs_s_r[2];
		ras_n = ras_s_r[2];
		cas_n = cas_s_r[2];
		we_n = we_s_r[2];
		ba = ba_s_r[8:6];
		addr = ad_s_r[38:26];
		is_mrs = ck_rise && !cs_n && !ras_n && !cas_n && !we_n;
		is_rd = ck_rise && !cs_n && ras_n && !cas_n && we_n;
		is_wr = ck_rise && !cs_n && ras_n && !cas_n && !we_n;
	end

	// Additive delay of zero, CL-1 or CL-2 in link cycles; CL taken as a parameter-free 14.
	always_comb begin
		case (mr1_r[`MR1_AL_HI:`MR1_AL_LO])
			2'h1: al_cyc = 4'hd;
			2'h2: al_cyc = 4'hc;
			default: al_cyc = 4'h0;
		endcase
		cwl_cyc = 4'(`CWL_BASE + {1'b0, mr2_r[`MR2_CWL_HI:`MR2_CWL_LO]});
	end

	// Mode registers: the bank pins alone choose which one is written.
	always_comb begin
		mr1_nxt = mr1_r;
		mr2_nxt = mr2_r;
		mr3_nxt = mr3_r;
		if (is_mrs) begin
			if (ba == `BANK_MR1) begin
				mr1_nxt = addr;
			end else if (ba == `BANK_MR2) begin
				mr2_nxt = addr;
			end else if (ba == `BANK_MR3) begin
				mr3_nxt = addr;
			end
		end
	end

	// Reads wait the additive delay plus one rise in a shift line, writes that delay plus the write latency summed in four bits, then act.
	always_comb begin
		al_pipe_nxt = al_pipe_r;
		wr_pipe_nxt = wr_pipe_r;
		fire_nxt = 1'b0;
		rdq_nxt = rdq_r;
		rvalid_nxt = 1'b0;
		if (ck_rise) begin
			al_pipe_nxt = {al_pipe_r[14:0], 1'b0};
			wr_pipe_nxt = {wr_pipe_r[14:0], 1'b0};
			if (is_rd) begin
				al_pipe_nxt[0] = 1'b1;
			end
			if (is_wr) begin
				wr_pipe_nxt[0] = 1'b1;
			end
			if (al_pipe_r[al_cyc]) begin
				rvalid_nxt = 1'b1;
				if (mr3_r[`MR3_PAT_EN_BIT]) begin
					// Pattern select bits are not read; readout always returns PATTERN_WORD.
					rdq_nxt = `PATTERN_WORD;
				end else begin
					rdq_nxt = addr[7:0];
				end
			end
			// The write's own rise is cycle zero, so the strobe taps one stage early.
			fire_nxt = wr_pipe_r[4'(al_cyc + cwl_cyc - 4'h1)];
		end
	end

	// Output enable, termination and status follow the mode fields.
	always_comb begin
		roe_nxt = rvalid_nxt && !mr1_r[`MR1_QOFF_BIT];
		lvl_nxt = mr1_r[`MR1_LEVEL_BIT];
		// Termination follows the third-stage pin, aligned with the write it came with.
		if (odt_s_r[2] && !mr1_r[`MR1_LEVEL_BIT]) begin
			term_nxt = mr2_r[`MR2_RTTWR_HI:`MR2_RTTWR_LO];
		end else begin
			term_nxt = 2'h0;
		end
		partial_array_retention_nxt = mr2_r[`MR2_PARTIAL_ARRAY_RETENTION_HI:`MR2_PARTIAL_ARRAY_RETENTION_LO];
		srt_nxt = mr2_r[`MR2_SRT_BIT];
		wl_nxt = 4'(al_cyc + cwl_cyc);
	end

	// All state registers; reset works in every mode, pattern readout included.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ck_s_r <= 3'h0;
			ck_q_r <= 1'b0;
			cs_s_r <= 3'h7;
			ras_s_r <= 3'h7;
			cas_s_r <= 3'h7;
			we_s_r <= 3'h7;
			ba_s_r <= 9'h000;
			ad_s_r <= 39'h0;
			odt_s_r <= 3'h0;
			mr1_r <= 13'h0000;
			mr2_r <= 13'h0000;
			mr3_r <= 13'h0000;
			al_pipe_r <= 16'h0000;
			wr_pipe_r <= 16'h0000;
			fire_r <= 1'b0;
			rdq_r <= 8'h00;
			rvalid_r <= 1'b0;
			roe_r <= 1'b0;
			term_r <= 2'h0;
			partial_array_retention_r <= 3'h0;
			srt_r <= 1'b0;
			wl_r <= 4'h0;
			lvl_r <= 1'b0;
		end else begin
			ck_s_r <= ck_s_nxt;
			ck_q_r <= ck_q_nxt;
			cs_s_r <= cs_s_nxt;
			ras_s_r <= ras_s_nxt;
			cas_s_r <= cas_s_nxt;
			we_s_r <= we_s_nxt;
			ba_s_r <= ba_s_nxt;
			ad_s_r <= ad_s_nxt;
			odt_s_r <= odt_s_nxt;
			mr1_r <= mr1_nxt;
			mr2_r <= mr2_nxt;
			mr3_r <= mr3_nxt;
			al_pipe_r <= al_pipe_nxt;
			wr_pipe_r <= wr_pipe_nxt;
			fire_r <= fire_nxt;
			rdq_r <= rdq_nxt;
			rvalid_r <= rvalid_nxt;
			roe_r <= roe_nxt;
			term_r <= term_nxt;
			partial_array_retention_r <= partial_array_retention_nxt;
			srt_r <= srt_nxt;
			wl_r <= wl_nxt;
			lvl_r <= lvl_nxt;
		end
	end

	assign link.dq_from_dev = rdq_r;
	assign link.dq_oe = roe_r;
	assign link.dq_valid = rvalid_r;
	assign link.term_sel = term_r;
	assign link.level_en = lvl_r;
	assign partial_array_retention_out = partial_array_retention_r;
	assign hot_self_refresh_rate_out = srt_r;
	assign total_write_delay_out = wl_r;
	assign write_fire_out = fire_r;
endmodule
`default_nettype wire

// [core/mode_reg_defines.svh]
// Shared constants for the DRAM mode-register decode and its controller.
`ifndef MODE_REG_DEFINES_SVH
`define MODE_REG_DEFINES_SVH
`define ADDR_W 13
`define BANK_W 3
`define BANK_MR0 3'h0
`define BANK_MR1 3'h1
`define BANK_MR2 3'h2
`define BANK_MR3 3'h3
`define MR1_QOFF_BIT 12
`define MR1_LEVEL_BIT 7
`define MR1_AL_LO 3
`define MR1_AL_HI 4
`define MR2_PARTIAL_ARRAY_RETENTION_LO 0
`define MR2_PARTIAL_ARRAY_RETENTION_HI 2
`define MR2_CWL_LO 3
`define MR2_CWL_HI 5
`define MR2_SRT_BIT 7
`define MR2_RTTWR_LO 9
`define MR2_RTTWR_HI 10
`define MR2_RSVD_MASK 13'h1900
`define MR3_PAT_LO 0
`define MR3_PAT_HI 1
`define MR3_PAT_EN_BIT 2
`define MR3_RSVD_MASK 13'h1ff8
`define CWL_BASE 4'h5
`define PATTERN_WORD 8'h55
`define LINK_DIV 4'h3
`define REFI_NORMAL_NS 10740
`define REFI_HOT_NS 7800
`define CLK_NS 20
`define APB_CTRL 12'h000
`define APB_MR_DATA 12'h004
`define APB_STATUS 12'h008
`define APB_MR2 12'h00c
`define APB_MR3 12'h010
`endif

// [core/mode_reg_pkg.sv]
// Types used by the controller end of the mode-register link and by the bench.
package mode_reg_pkg;
	typedef enum logic [2:0] {
		CMD_NOP = 3'b000,
		CMD_MRS = 3'b001,
		CMD_READ = 3'b010,
		CMD_READ_AP = 3'b011,
		CMD_WRITE = 3'b100,
		CMD_REFRESH = 3'b101,
		CMD_SELF_REF = 3'b110
	} cmd_t;
endpackage

// [tb/dram_link_assertions.sv]
// Checker watching the command link between the controller and DRAM ends.
`timescale 1ns/1ps
`default_nettype none
`include "mode_reg_defines.svh"
module dram_link_assertions (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ck,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] ba,
	input wire logic [12:0] addr,
	input wire logic [7:0] dq_from_dev,
	input wire logic dq_oe,
	input wire logic dq_valid,
	input wire logic odt,
	input wire logic [1:0] term_sel,
	input wire logic level_en
);
	logic ck_d_r, ck_d_nxt, qoff_r, qoff_nxt, lvl_r, lvl_nxt, pat_r, pat_nxt, rise, mrs, rd;
	logic [1:0] rtt_r, rtt_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// Decode of the command carried at each link clock rise.
	assign rise = ck && !ck_d_r;
	assign mrs = !cs_n && !ras_n && !cas_n && !we_n;
	assign rd = !cs_n && ras_n && !cas_n && we_n;
	// Shadow settings plus a settling count, since the device filters the link clock.
	always_comb begin
		ck_d_nxt = ck;
		qoff_nxt = qoff_r;
		lvl_nxt = lvl_r;
		pat_nxt = pat_r;
		rtt_nxt = rtt_r;
		cnt_nxt = cnt_r + {3'h0, ~&cnt_r};
		if (rise && mrs) begin
			cnt_nxt = 4'h0;
			case (ba)
				`BANK_MR1: begin
					qoff_nxt = addr[`MR1_QOFF_BIT];
					lvl_nxt = addr[`MR1_LEVEL_BIT];
				end
				`BANK_MR2: rtt_nxt = addr[`MR2_RTTWR_HI:`MR2_RTTWR_LO];
				`BANK_MR3: pat_nxt = addr[`MR3_PAT_EN_BIT];
				default: cnt_nxt = 4'h0;
			endcase
		end
	end
	// Registers of the shadow state.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ck_d_r <= 1'b0;
			qoff_r <= 1'b0;
			lvl_r <= 1'b0;
			pat_r <= 1'b0;
			rtt_r <= 2'h0;
			cnt_r <= 4'hf;
		end else begin
			ck_d_r <= ck_d_nxt;
			qoff_r <= qoff_nxt;
			lvl_r <= lvl_nxt;
			pat_r <= pat_nxt;
			rtt_r <= rtt_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	output_disable_a: assert property (qoff_r && cnt_r[3] |-> !dq_oe)
		else $error("data driver enabled while outputs are disabled");
	level_hold_a: assert property (cnt_r[3] |-> level_en == lvl_r)
		else $error("leveling flag differs from last written value");
	level_term_a: assert property (level_en |-> term_sel == 2'h0)
		else $error("write termination used during leveling");
	write_term_a: assert property ($rose(odt) && !level_en |-> ##[1:8] term_sel == rtt_r)
		else $error("write termination not applied");
	pattern_data_a: assert property (dq_valid && dq_oe && pat_r |-> dq_from_dev == `PATTERN_WORD)
		else $error("read did not return the calibration pattern");
	pins_hold_a: assert property (rise |=> $stable({cs_n, ras_n, cas_n, we_n, ba, addr})[*3])
		else $error("command pins changed before link clock fall");
	mr2_reserved_a: assert property (rise && mrs && ba == `BANK_MR2 |-> (addr & `MR2_RSVD_MASK) == 13'h0)
		else $error("reserved register two bits driven high");
	mr3_reserved_a: assert property (rise && mrs && ba == `BANK_MR3 |-> (addr & `MR3_RSVD_MASK) == 13'h0)
		else $error("reserved register three bits driven high");
	pattern_only_a: assert property (rise && !cs_n && pat_r |-> rd || mrs)
		else $error("non-read command while pattern readout on");
	other_bank_a: assert property (rise && mrs && ba != `BANK_MR1 |=> $stable(level_en)[*8])
		else $error("register one changed by another bank");
endmodule
`default_nettype wire

// [tb/test_dram_mode_reg_two_three_decode.sv]
// Bench joining the controller and DRAM ends over the command link.
`timescale 1ns/1ps
`default_nettype none
`include "mode_reg_defines.svh"
module test_dram_mode_reg_two_three_decode;
	logic clk_in, rst_n_in, psel, penable, pwrite, pready_out, pslverr_out, hot, fire, err, serr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata_out, rdat;
	logic [2:0] partial_array_retention;
	logic [3:0] twl;
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	int fires = 0;
	dram_cmd_if u_link();
	dram_mode_controller u_dram_mode_controller (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.link(u_link), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out));
	dram_mode_reg_two_three_decode u_dram_mode_reg_two_three_decode (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .link(u_link), .partial_array_retention_out(partial_array_retention),
		.hot_self_refresh_rate_out(hot), .total_write_delay_out(twl), .write_fire_out(fire));
	dram_link_assertions u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .ck(u_link.ck),
		.cs_n(u_link.cs_n), .ras_n(u_link.ras_n), .cas_n(u_link.cas_n), .we_n(u_link.we_n),
		.ba(u_link.ba), .addr(u_link.addr), .dq_from_dev(u_link.dq_from_dev),
		.dq_oe(u_link.dq_oe), .dq_valid(u_link.dq_valid), .odt(u_link.odt),
		.term_sel(u_link.term_sel), .level_en(u_link.level_en));
	// Clock source.
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	// Counts write completions and cuts a hang short.
	always @(posedge clk_in) begin
		fires += (fire === 1'b1);
		cycles++;
		if (cycles == 20000) begin
			failures++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		r = prdata_out;
		e = pslverr_out;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Issues one link command, then waits for busy to clear and the device to settle.
	task automatic cmd(input mode_reg_pkg::cmd_t c, input logic [2:0] b, input logic [12:0] a);
		apb(1'b1, `APB_MR_DATA, {13'h0, a, b, c}, rdat, err);
		do apb(1'b0, `APB_STATUS, 32'h0, rdat, serr); while (rdat[0] !== 1'b0);
		repeat (16) @(posedge clk_in);
	endtask
	task automatic t_mr2();
		logic [2:0] p;
		int f;
		int k;
		logic ck_d;
		for (int i = 0; i < 8; i++) begin
			p = ~i[2:0];
			cmd(mode_reg_pkg::CMD_MRS, `BANK_MR2, {2'h3, i[1:0], 1'b1, i[0], 1'b0, i[2:0], p});
			cmp(partial_array_retention, p);
			cmp(hot, i[0]);
			cmp(twl, `CWL_BASE + i[2:0]);
			f = fires;
			k = -1;
			apb(1'b1, `APB_MR_DATA, {26'h0, 3'h0, mode_reg_pkg::CMD_WRITE}, rdat, err);
			ck_d = u_link.ck;
			// Count link clock rises from the write's own rise up to the write strobe.
			for (int n = 0; n < 300 && fire !== 1'b1; n++) begin
				@(posedge clk_in);
				if (u_link.ck && !ck_d && (k >= 0 || !u_link.we_n)) begin
					k++;
				end
				ck_d = u_link.ck;
			end
			@(posedge clk_in);
			cmp(k, `CWL_BASE + i[2:0]);
			cmp(fires, f + 1);
		end
		$display("t_mr2 done");
	endtask
	task automatic t_pattern();
		cmd(mode_reg_pkg::CMD_MRS, `BANK_MR3, 13'h1fff);
		apb(1'b1, `APB_MR_DATA, {26'h0, 3'h0, mode_reg_pkg::CMD_READ}, rdat, err);
		for (int n = 0; n < 300 && u_link.dq_valid !== 1'b1; n++) @(posedge clk_in);
		cmp(u_link.dq_oe, 1'b1);
		cmp(u_link.dq_from_dev, `PATTERN_WORD);
		apb(1'b0, `APB_STATUS, 32'h0, rdat, serr);
		cmp(rdat[9:2], `PATTERN_WORD);
		cmd(mode_reg_pkg::CMD_WRITE, 3'h0, 13'h0);
		cmp(err, 1'b1);
		cmd(mode_reg_pkg::CMD_READ_AP, 3'h0, 13'h0);
		cmp(err, 1'b0);
		cmp(hot, 1'b1);
		cmd(mode_reg_pkg::CMD_MRS, `BANK_MR3, 13'h0003);
		cmd(mode_reg_pkg::CMD_READ, 3'h0, 13'h0);
		apb(1'b0, `APB_STATUS, 32'h0, rdat, serr);
		cmp(rdat[9:2] == `PATTERN_WORD, 1'b0);
		cmd(mode_reg_pkg::CMD_WRITE, 3'h0, 13'h0);
		cmp(err, 1'b0);
		$display("t_pattern done");
	endtask
	task automatic t_qoff_hot();
		cmd(mode_reg_pkg::CMD_MRS, `BANK_MR1, 13'h1080);
		cmd(mode_reg_pkg::CMD_WRITE, 3'h0, 13'h0);
		cmd(mode_reg_pkg::CMD_MRS, `BANK_MR3, 13'h0004);
		apb(1'b1, `APB_MR_DATA, {26'h0, 3'h0, mode_reg_pkg::CMD_READ}, rdat, err);
		for (int n = 0; n < 300 && u_link.dq_valid !== 1'b1; n++) @(posedge clk_in);
		cmp(u_link.dq_valid, 1'b1);
		cmp(u_link.dq_oe, 1'b0);
		cmd(mode_reg_pkg::CMD_MRS, `BANK_MR3, 13'h0000);
		cmd(mode_reg_pkg::CMD_MRS, `BANK_MR1, 13'h0000);
		apb(1'b1, `APB_CTRL, 32'h1, rdat, serr);
		cmd(mode_reg_pkg::CMD_MRS, `BANK_MR2, 13'h0000);
		cmd(mode_reg_pkg::CMD_SELF_REF, 3'h0, 13'h0);
		cmp(err, 1'b1);
		apb(1'b1, `APB_CTRL, 32'h0, rdat, serr);
		apb(1'b0, 12'h100, 32'h0, rdat, serr);
		cmp(serr, 1'b1);
		cmp(rdat, 32'h0);
		$display("t_qoff_hot done");
	endtask
	task automatic t_reset();
		cmd(mode_reg_pkg::CMD_MRS, `BANK_MR2, 13'h00bf);
		cmd(mode_reg_pkg::CMD_MRS, `BANK_MR3, 13'h0004);
		rst_n_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		cmp({partial_array_retention, hot, twl}, 8'h00);
		cmd(mode_reg_pkg::CMD_WRITE, 3'h0, 13'h0);
		cmp(err, 1'b0);
		$display("t_reset done");
	endtask
	// Main sequence.
	initial begin
		rst_n_in = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_mr2();
		t_pattern();
		t_qoff_hot();
		t_reset();
		summarize();
	end
endmodule
`default_nettype wire
